// >>> logic/ccs_converter.sv
`timescale 1ns/1ps
// How it works
// RULE1: Select code makes converter selected
// RULE2: Each converter answers own select/deselect pair
// RULE3: Selected converter is active, others inactive
// RULE4: Deadstart master clear selects every converter
// RULE5: Stays selected until its deselect code
// RULE6: Second converter deselects only after first
// RULE7: Connect activates exactly one of eight
// RULE8: Bits 11..9 equipment, 8..0 unit
// RULE9: Upper digit 4..7 forwarded as connect
// RULE10: Connection ends on reconnect or clears
// RULE11: Reply sends inactive to channel
// RULE12: Reject sends inactive, sets bit 0
// RULE13: 100 us silence: internal reject, bits 0,1
// RULE14: Controller parity error yields no response
// RULE15: Code 1000 arms mode II connect
// RULE16: Next output word becomes connect code
// RULE17: Mode II responses send empty to channel
// RULE18: Processor waits full, then disconnects
// RULE19: Processor checks reject after mode II
// RULE20: Upper digit 0 forwarded as function
// RULE21: Function reject/timeout set status bits
// RULE22: Code 1100 arms mode II function
// RULE23: Processor reads status after functions
// RULE24: Code 1700 clears controllers and converter
// RULE25: Code 1200 presents status as input
// RULE26: Timeout is cycle counter from clock
// RULE27: Deselected converter ignores other codes
module ccs_converter #(
  parameter logic [11:0] SELECT_CODE = ccs_pkg::CCS_FN_SELECT_DEF,
  parameter logic [11:0] DESELECT_CODE = ccs_pkg::CCS_FN_DESELECT_DEF,
  parameter int TIMEOUT_CYC = ccs_pkg::CCS_TIMEOUT_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic deadstart_clear_i,
  input wire ccs_pkg::ccs_chan_in_t chan_i,
  input wire logic prior_selected_i,
  input wire logic reply_i,
  input wire logic reject_i,
  input wire logic [2:0] sw_addr_i,
  input wire logic sw_rd_i,
  output logic [11:0] sw_rdata_o,
  output ccs_pkg::ccs_ctl_out_t ctl_o,
  output logic [7:0] eq_active_o,
  output logic selected_o,
  output logic chan_inactive_o,
  output logic chan_empty_o,
  output logic status_avail_o,
  output logic [11:0] status_word_o
);
  import ccs_pkg::*;

  // Software read map, word index
  localparam logic [2:0] SW_STATUS = 3'h0;
  localparam logic [2:0] SW_STATE = 3'h1;
  localparam logic [2:0] SW_CONN = 3'h2;

  // All state of the block in one record
  typedef struct packed {
    ccs_state_t st;
    logic selected;
    logic conn_valid;
    logic [2:0] conn_eq;
    logic arm_conn;
    logic arm_func;
    logic mode2;
    logic [31:0] timer;
    logic [11:0] status;
    ccs_ctl_out_t ctl;
    logic inactive;
    logic empty;
    logic status_avail;
    logic [11:0] rdata;
    logic [7:0] eq_active; // Registered one-hot connect lines
  } ccs_regs_t;

  ccs_regs_t s_reg;
  ccs_regs_t s_next;
  logic is_func; // Function word from channel
  logic is_data; // Data word from channel
  logic [2:0] top_digit; // Upper octal digit

  assign is_func = chan_i.func;
  assign is_data = chan_i.data;
  assign top_digit = chan_i.word[CCS_EQ_MSB:CCS_EQ_LSB];

  // Next-state logic
  always_comb begin
    s_next = s_reg;
    // Pulses last one cycle
    s_next.ctl.connect = 1'b0;
    s_next.ctl.func = 1'b0;
    s_next.ctl.mclear = 1'b0;
    s_next.inactive = 1'b0;
    s_next.empty = 1'b0;
    s_next.rdata = 12'h000;
    // Software read port, answer one cycle later
    if (sw_rd_i) begin
      unique case (sw_addr_i)
        SW_STATUS: s_next.rdata = s_reg.status;
        SW_STATE: s_next.rdata = {7'h00, s_reg.arm_func, s_reg.arm_conn,
                                  s_reg.conn_valid, s_reg.st != CCS_IDLE, s_reg.selected};
        SW_CONN: s_next.rdata = {9'h000, s_reg.conn_eq};
        default: s_next.rdata = 12'h000;
      endcase
    end
    // Waiting for controller response
    unique case (s_reg.st)
      CCS_IDLE: begin
        // Nothing pending
      end
      CCS_WAIT_CONN, CCS_WAIT_FUNC: begin
        if (reply_i) begin
          // RULE11: reply frees channel
          s_next.status[CCS_ST_REJECT] = 1'b0;
          s_next.status[CCS_ST_INT_REJECT] = 1'b0;
          s_next.st = CCS_DONE;
          if (s_reg.st == CCS_WAIT_CONN) begin
            // RULE7: only one connected
            s_next.conn_valid = 1'b1;
            s_next.conn_eq = s_reg.ctl.code[CCS_EQ_MSB:CCS_EQ_LSB];
          end
        end else if (reject_i) begin
          // RULE12: RULE21: reject sets bit 0
          s_next.status[CCS_ST_REJECT] = 1'b1;
          s_next.status[CCS_ST_INT_REJECT] = 1'b0;
          s_next.st = CCS_DONE;
        end else if (s_reg.timer == 32'h0000_0001) begin
          // RULE13: RULE14: silence ends in internal reject
          s_next.status[CCS_ST_REJECT] = 1'b1;
          s_next.status[CCS_ST_INT_REJECT] = 1'b1;
          s_next.st = CCS_DONE;
        end else begin
          // RULE26: count down to timeout
          s_next.timer = s_reg.timer - 32'h0000_0001;
        end
      end
      CCS_DONE: begin
        // RULE17: mode II answers with empty, else inactive
        if (s_reg.mode2) begin
          s_next.empty = 1'b1;
        end else begin
          s_next.inactive = 1'b1;
        end
        s_next.st = CCS_IDLE;
        s_next.timer = 32'h0000_0000;
      end
      default: s_next.st = CCS_IDLE;
    endcase
    // Status consumed by one-word input; a 1200 below wins over the clear
    if (s_reg.status_avail && chan_i.data == 1'b0 && sw_rd_i && sw_addr_i == SW_STATUS) begin
      s_next.status_avail = 1'b0;
    end
    // Codes from the channel
    if (is_func) begin
      if (!s_reg.selected) begin
        // RULE1: RULE2: RULE27: own select code only
        if (chan_i.word == SELECT_CODE) begin
          s_next.selected = 1'b1;
        end
      // RULE5: RULE6: deselect after prior converter
      end else if (chan_i.word == DESELECT_CODE && !prior_selected_i) begin
        s_next.selected = 1'b0;
      end else if (s_reg.st == CCS_IDLE) begin
        s_next.arm_conn = 1'b0;
        s_next.arm_func = 1'b0;
        if (top_digit >= 3'd4) begin
          // RULE9: RULE8: mode I connect, whole code forwarded
          s_next.ctl.connect = 1'b1;
          s_next.ctl.code = chan_i.word;
          s_next.st = CCS_WAIT_CONN;
          s_next.mode2 = 1'b0;
          s_next.timer = 32'(TIMEOUT_CYC);
        end else if (top_digit == 3'd0) begin
          // RULE20: mode I function, 9-bit
          s_next.ctl.func = 1'b1;
          s_next.ctl.code = chan_i.word;
          s_next.st = CCS_WAIT_FUNC;
          s_next.mode2 = 1'b0;
          s_next.timer = 32'(TIMEOUT_CYC);
        end else if (chan_i.word == CCS_FN_CONNECT_INIT) begin
          // RULE15: arm mode II connect
          s_next.arm_conn = 1'b1;
          s_next.inactive = 1'b1;
        end else if (chan_i.word == CCS_FN_FUNC_INIT) begin
          // RULE22: arm mode II function
          s_next.arm_func = 1'b1;
          s_next.inactive = 1'b1;
        end else if (chan_i.word == CCS_FN_STATUS_REQ) begin
          // RULE25: status ready as next input
          s_next.status_avail = 1'b1;
          s_next.inactive = 1'b1;
        end else if (chan_i.word == CCS_FN_MASTER_CLEAR) begin
          // RULE24: RULE10: clear controllers and all conditions
          s_next.ctl.mclear = 1'b1;
          s_next.conn_valid = 1'b0;
          s_next.status = CCS_STATUS_RST;
          s_next.status_avail = 1'b0;
          s_next.inactive = 1'b1;
        end
      end
    end else if (is_data && s_reg.selected && s_reg.st == CCS_IDLE) begin
      if (s_reg.arm_conn || s_reg.arm_func) begin
        // RULE16: RULE22: data word forwarded as code
        s_next.ctl.connect = s_reg.arm_conn;
        s_next.ctl.func = s_reg.arm_func;
        s_next.ctl.code = chan_i.word;
        s_next.st = s_reg.arm_conn ? CCS_WAIT_CONN : CCS_WAIT_FUNC;
        s_next.mode2 = 1'b1;
        s_next.timer = 32'(TIMEOUT_CYC);
        s_next.arm_conn = 1'b0;
        s_next.arm_func = 1'b0;
      end
    end
    // RULE3: RULE7: one-hot activation of next connection
    s_next.eq_active = s_next.conn_valid ? (8'h01 << s_next.conn_eq) : 8'h00;
  end

  // Registers; deadstart dominates
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.st <= CCS_IDLE;
      // RULE4: reset selects converter
      s_reg.selected <= 1'b1;
    end else if (ce_i) begin
      if (deadstart_clear_i) begin
        s_reg <= '0;
        s_reg.st <= CCS_IDLE;
        // RULE4: RULE10: deadstart selects, drops connection
        s_reg.selected <= 1'b1;
        s_reg.ctl.mclear <= 1'b1;
      end else begin
        s_reg <= s_next;
      end
    end
  end

  // Outputs straight from flip-flops
  assign ctl_o = s_reg.ctl;
  // Registered connect lines, no decode after the flops
  assign eq_active_o = s_reg.eq_active;
  assign selected_o = s_reg.selected;
  assign chan_inactive_o = s_reg.inactive;
  assign chan_empty_o = s_reg.empty;
  assign status_avail_o = s_reg.status_avail;
  assign status_word_o = s_reg.status;
  assign sw_rdata_o = s_reg.rdata;

  // RULE13: timeout leads to internal reject
  a_timeout_reject: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE13
    ce_i && !deadstart_clear_i && s_reg.st inside {CCS_WAIT_CONN, CCS_WAIT_FUNC}
    && s_reg.timer == 32'h0000_0001 && !reply_i && !reject_i
    |=> s_reg.status[1:0] == 2'b11)
    else $error("timeout did not set both reject bits");

  // RULE12: external reject sets only bit 0
  a_reject_bit: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE12
    ce_i && !deadstart_clear_i && s_reg.st inside {CCS_WAIT_CONN, CCS_WAIT_FUNC}
    && !reply_i && reject_i |=> s_reg.status[1:0] == 2'b01)
    else $error("reject did not set bit 0 alone");

  // RULE7: at most one equipment active
  a_one_active: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE7
    $onehot0(eq_active_o))
    else $error("more than one equipment active");

  // RULE11: reply answered by inactive next
  a_reply_free: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE11
    ce_i && !deadstart_clear_i && s_reg.st == CCS_DONE && !s_reg.mode2
    |=> chan_inactive_o && !chan_empty_o)
    else $error("inactive not sent after mode I response");

  // RULE17: mode II response sends empty
  a_mode2_empty: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE17
    ce_i && !deadstart_clear_i && s_reg.st == CCS_DONE && s_reg.mode2
    |=> chan_empty_o && !chan_inactive_o)
    else $error("empty not sent after mode II response");

  // RULE4: deadstart selects converter
  a_deadstart_sel: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE4
    ce_i && deadstart_clear_i |=> selected_o && eq_active_o == 8'h00)
    else $error("deadstart did not select");

  // RULE15: connect initiate not forwarded
  a_init_local: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE15
    ce_i && !deadstart_clear_i && s_reg.selected && s_reg.st == CCS_IDLE && is_func
    && chan_i.word == CCS_FN_CONNECT_INIT
    |=> !ctl_o.connect && !ctl_o.func && chan_inactive_o)
    else $error("connect initiate was forwarded");

  // RULE27: deselected converter forwards nothing
  a_desel_quiet: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE27
    ce_i && !deadstart_clear_i && !s_reg.selected
    |=> !ctl_o.connect && !ctl_o.func)
    else $error("deselected converter forwarded a code");

  // RULE9: mode I connect forwarded whole
  a_connect_fwd: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE9
    ce_i && !deadstart_clear_i && s_reg.selected && s_reg.st == CCS_IDLE && is_func
    && chan_i.word != DESELECT_CODE && top_digit >= 3'd4
    |=> ctl_o.connect && !ctl_o.func && ctl_o.code == $past(chan_i.word))
    else $error("mode I connect code not forwarded");

  // RULE20: mode I function forwarded
  a_func_fwd: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE20
    ce_i && !deadstart_clear_i && s_reg.selected && s_reg.st == CCS_IDLE && is_func
    && chan_i.word != DESELECT_CODE && top_digit == 3'd0
    |=> ctl_o.func && !ctl_o.connect && ctl_o.code == $past(chan_i.word))
    else $error("mode I function code not forwarded");

  // RULE16: armed data word becomes connect
  a_mode2_fwd: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE16
    ce_i && !deadstart_clear_i && s_reg.selected && s_reg.st == CCS_IDLE && !is_func
    && is_data && s_reg.arm_conn
    |=> ctl_o.connect && ctl_o.code == $past(chan_i.word))
    else $error("mode II connect word not forwarded");

  // RULE6: deselect waits for prior converter
  a_deselect_order: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE6
    ce_i && !deadstart_clear_i && s_reg.selected && is_func
    && chan_i.word == DESELECT_CODE && prior_selected_i
    |=> selected_o)
    else $error("deselected before the prior converter");

  // RULE10: deselect keeps the connection
  a_conn_kept: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE10
    ce_i && !deadstart_clear_i && s_reg.selected && s_reg.st == CCS_IDLE && is_func
    && chan_i.word == DESELECT_CODE && !prior_selected_i
    |=> $stable(eq_active_o) && !selected_o)
    else $error("deselect dropped the connection");

  // RULE25: status offered as next input
  a_status_offer: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE25
    ce_i && !deadstart_clear_i && s_reg.selected && s_reg.st == CCS_IDLE && is_func
    && chan_i.word == CCS_FN_STATUS_REQ
    |=> status_avail_o && chan_inactive_o)
    else $error("status request not offered");

  // RULE24: master clear empties everything
  a_master_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE24
    ce_i && !deadstart_clear_i && s_reg.selected && s_reg.st == CCS_IDLE && is_func
    && chan_i.word == CCS_FN_MASTER_CLEAR
    |=> ctl_o.mclear && eq_active_o == 8'h00 && status_word_o == 12'h000 && chan_inactive_o)
    else $error("master clear left state behind");
endmodule

// >>> logic/ccs_pkg.sv
package ccs_pkg;
  // Channel function codes (octal)
  localparam logic [11:0] CCS_FN_CONNECT_INIT = 12'o1000;
  localparam logic [11:0] CCS_FN_FUNC_INIT = 12'o1100;
  localparam logic [11:0] CCS_FN_STATUS_REQ = 12'o1200;
  localparam logic [11:0] CCS_FN_MASTER_CLEAR = 12'o1700;
  localparam logic [11:0] CCS_FN_SELECT_DEF = 12'o2000;
  localparam logic [11:0] CCS_FN_DESELECT_DEF = 12'o2100;
  // Field positions of a connect code
  localparam int CCS_EQ_LSB = 9;
  localparam int CCS_EQ_MSB = 11;
  localparam int CCS_UNIT_MSB = 8;
  // Status bit positions
  localparam int CCS_ST_REJECT = 0;
  localparam int CCS_ST_INT_REJECT = 1;
  // Response timeout
  localparam int CCS_CLK_MHZ = 200;
  localparam int CCS_TIMEOUT_US = 100;
  localparam int CCS_TIMEOUT_CYC = CCS_TIMEOUT_US * CCS_CLK_MHZ;
  localparam logic [11:0] CCS_STATUS_RST = 12'h000;

  // Word arriving from the data channel
  typedef struct packed {
    logic func;
    logic data;
    logic [11:0] word;
  } ccs_chan_in_t;

  // Word and strobes toward the controllers
  typedef struct packed {
    logic connect;
    logic func;
    logic mclear;
    logic [11:0] code;
  } ccs_ctl_out_t;

  // Pending operation
  typedef enum logic [3:0] {
    CCS_IDLE = 4'b0001,
    CCS_WAIT_CONN = 4'b0010,
    CCS_WAIT_FUNC = 4'b0100,
    CCS_DONE = 4'b1000
  } ccs_state_t;
endpackage

// >>> tb/ccs_ctl_model.sv
`timescale 1ns/1ps
// Stand-in for the eight attached controllers: answers each forwarded code in modes 0 and 1 only
module ccs_ctl_model (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire ccs_pkg::ccs_ctl_out_t ctl_i,
  input wire logic [1:0] mode_i,
  input wire logic [3:0] delay_i,
  output logic reply_o,
  output logic reject_o
);
  import ccs_pkg::*;
  logic busy_reg; // Response owed
  logic [3:0] cnt_reg; // Cycles left before answering
  // reply or reject after a delay
  // mode 2 stays silent, like a parity fault; clear drops it
  always_ff @(posedge clk_sys_i) begin
    reply_o <= 1'b0;
    reject_o <= 1'b0;
    if (rst_i || ctl_i.mclear) begin
      busy_reg <= 1'b0;
      cnt_reg <= 4'h0;
    end else if (ctl_i.connect || ctl_i.func) begin
      busy_reg <= (mode_i != 2'd2);
      cnt_reg <= delay_i;
    end else if (busy_reg && cnt_reg == 4'h0) begin
      // Answer once, then fall quiet
      busy_reg <= 1'b0;
      reply_o <= (mode_i == 2'd0);
      reject_o <= (mode_i == 2'd1);
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end
endmodule

// >>> tb/tb_channel_converter_select_connect.sv
`timescale 1ns/1ps
module tb_channel_converter_select_connect;
  import ccs_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic deadstart_clear_i = 1'b0;
  ccs_chan_in_t chan_i = '0;
  logic prior_selected_i = 1'b0;
  logic reply_i, reject_i;
  logic [2:0] sw_addr_i = 3'h0;
  logic sw_rd_i = 1'b0;
  logic [11:0] sw_rdata_o, status_word_o;
  ccs_ctl_out_t ctl_o;
  logic [7:0] eq_active_o;
  logic selected_o, chan_inactive_o, chan_empty_o, status_avail_o;
  logic [1:0] mode = 2'd0; // 0 reply, 1 reject, 2 silent
  int mismatches = 0;
  int tests_run = 0;
  int n;
  localparam int TO_CYC = 20; // Short response timeout for simulation
  // 200 MHz system clock
  always #2.5 clk_sys_i = ~clk_sys_i;
  // Own pair 2200/2300 so that the default pair must be ignored
  ccs_converter #(.SELECT_CODE(12'o2200), .DESELECT_CODE(12'o2300), .TIMEOUT_CYC(TO_CYC)) dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .deadstart_clear_i(deadstart_clear_i),
    .chan_i(chan_i), .prior_selected_i(prior_selected_i), .reply_i(reply_i),
    .reject_i(reject_i), .sw_addr_i(sw_addr_i), .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o),
    .ctl_o(ctl_o), .eq_active_o(eq_active_o), .selected_o(selected_o),
    .chan_inactive_o(chan_inactive_o), .chan_empty_o(chan_empty_o),
    .status_avail_o(status_avail_o), .status_word_o(status_word_o));
  ccs_ctl_model ctl (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ctl_i(ctl_o), .mode_i(mode),
    .delay_i(4'h2), .reply_o(reply_i), .reject_o(reject_i));
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One word from the channel; ends settled after the taking edge
  task automatic send(input logic is_data, input logic [11:0] w);
    @(posedge clk_sys_i);
    chan_i <= '{func: !is_data, data: is_data, word: w};
    @(posedge clk_sys_i);
    chan_i <= '0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, input logic [11:0] exp, input string what);
    @(posedge clk_sys_i);
    sw_rd_i <= 1'b1;
    sw_addr_i <= a;
    @(posedge clk_sys_i);
    sw_rd_i <= 1'b0;
    #1;
    chk(what, exp, sw_rdata_o);
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return chan_inactive_o;
      1: return chan_empty_o;
      2: return ctl_o.mclear;
      default: return chan_inactive_o | chan_empty_o;
    endcase
  endfunction
  // Bounded wait for a one-cycle pulse; a miss ends the run
  task automatic wait_for(input int s);
    for (n = 0; n < 100; n++) begin
      if (sig(s) === 1'b1) return;
      @(posedge clk_sys_i);
      #1;
    end
    mismatches++;
    $display("MISMATCH wait pulse %0d expected 1 seen 0", s);
    final_report();
  endtask
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    #1;
    chk("selected", 12'h001, {11'h0, selected_o});
    send(0, 12'o2100);
    chk("selected", 12'h001, {11'h0, selected_o});
    send(0, 12'o2300);
    chk("selected", 12'h000, {11'h0, selected_o});
    send(0, 12'o4005);
    repeat (6) @(posedge clk_sys_i);
    rd(3'h2, 12'h000, "eq reg");
    send(0, 12'o2200);
    chk("selected", 12'h001, {11'h0, selected_o});
    send(0, 12'o4005);
    chk("ctl code", 12'o4005, ctl_o.code);
    chk("ctl connect", 12'h001, {11'h0, ctl_o.connect});
    wait_for(0);
    chk("eq active", 12'h010, {4'h0, eq_active_o});
    send(0, 12'o2300);
    chk("eq kept", 12'h010, {4'h0, eq_active_o});
    send(0, 12'o2200);
    prior_selected_i <= 1'b1;
    send(0, 12'o2300);
    chk("selected", 12'h001, {11'h0, selected_o});
    prior_selected_i <= 1'b0;
    mode <= 2'd1;
    send(0, 12'o5007);
    wait_for(0);
    chk("status", 12'h001, status_word_o);
    mode <= 2'd2;
    send(0, 12'o0003);
    chk("ctl func", 12'h001, {11'h0, ctl_o.func});
    wait_for(0);
    chk("timeout length", 12'(TO_CYC + 1), 12'(n));
    chk("status", 12'h003, status_word_o);
    send(0, 12'o1200);
    chk("status avail", 12'h001, {11'h0, status_avail_o});
    rd(3'h0, 12'h003, "status reg");
    mode <= 2'd0;
    send(0, 12'o1000);
    chk("no forward", 12'h000, {11'h0, ctl_o.connect});
    wait_for(0);
    rd(3'h1, 12'h00D, "arm state");
    send(1, 12'o1003);
    chk("ctl code", 12'o1003, ctl_o.code);
    wait_for(1);
    chk("eq active", 12'h002, {4'h0, eq_active_o});
    rd(3'h0, 12'h000, "status reg");
    send(0, 12'o1100);
    wait_for(0);
    send(1, 12'o7777);
    chk("ctl code", 12'o7777, ctl_o.code);
    chk("ctl func", 12'h001, {11'h0, ctl_o.func});
    wait_for(1);
    rd(3'h0, 12'h000, "status reg");
    send(0, 12'o1700);
    wait_for(2);
    repeat (2) @(posedge clk_sys_i);
    chk("eq cleared", 12'h000, {4'h0, eq_active_o});
    chk("status", 12'h000, status_word_o);
    send(0, 12'o2300);
    chk("selected", 12'h000, {11'h0, selected_o});
    @(posedge clk_sys_i);
    deadstart_clear_i <= 1'b1;
    @(posedge clk_sys_i);
    deadstart_clear_i <= 1'b0;
    #1;
    chk("selected", 12'h001, {11'h0, selected_o});
    final_report();
  end
endmodule
